// ===== shared/apc_defs.vh
/*
 * Register map, reset values and timing counts for the analog port pin
 * configuration block. Assumes a word-addressed Avalon-MM slave whose
 * address port carries the register index (printed offset) directly.
 */
`ifndef APC_DEFS_VH
`define APC_DEFS_VH

`define APC_ADDR_W 10
`define APC_OFS_LOW_DATA 10'h270
`define APC_OFS_UP_DATA 10'h271
`define APC_OFS_LOW_DIR 10'h272
`define APC_OFS_UP_DIR 10'h273
`define APC_OFS_DRV0 10'h274
`define APC_OFS_DRV1 10'h275
`define APC_OFS_PULL0 10'h276
`define APC_OFS_PULL1 10'h277
`define APC_OFS_POL0 10'h278
`define APC_OFS_POL1 10'h279
`define APC_OFS_DIEN0 10'h27A
`define APC_OFS_DIEN1 10'h27B
`define APC_RST_BYTE 8'h00
`define APC_SYNC_STAGES 2
`define APC_UNMAPPED_DATA 32'h00000000

`endif

// ===== hw/apc_pin_sync.v
/*
 * Two-stage synchroniser for sixteen pin input levels.
 * Assumes pins change freely relative to sys_clk.
 */
module apc_pin_sync (
    input wire sys_clk,
    input wire arst_n,
    input wire [15:0] pin_in,
    output wire [15:0] pin_sync
);
    reg [15:0] meta_ff;
    reg [15:0] sync_ff;

    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_ff <= 16'h0000;
            sync_ff <= 16'h0000;
        end else begin
            meta_ff <= pin_in;
            sync_ff <= meta_ff;
        end
    end

    assign pin_sync = sync_ff;
endmodule // apc_pin_sync

// ===== hw/apc_port.v
`include "apc_defs.vh"
/*
 * Configuration and data logic for sixteen analog-shared port pins in two
 * groups of eight. Assumes an Avalon-MM master with waitrequest; the pad
 * ring takes the per-pin controls produced here.
 */
module apc_port (
    input wire sys_clk,
    input wire arst_n,
    input wire [9:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    input wire [15:0] pin_in,
    input wire [15:0] alt_out_en,
    input wire [15:0] alt_out_val,
    output reg [15:0] pin_out,
    output reg [15:0] pin_oe,
    output reg [15:0] pin_reduced_drive,
    output reg [15:0] pin_pull_en,
    output reg [15:0] pin_pull_up,
    output reg [15:0] pin_digital_in_en
);

////////////////////////////////////////////////////////////////////////////////

    reg [7:0] lower_pin_data_ff;
    reg [7:0] upper_pin_data_ff;
    reg [7:0] lower_pin_direction_ff;
    reg [7:0] upper_pin_direction_ff;
    reg [7:0] group0_drive_strength_ff;
    reg [7:0] group1_drive_strength_ff;
    reg [7:0] group0_pull_enable_ff;
    reg [7:0] group1_pull_enable_ff;
    reg [7:0] group0_polarity_ff;
    reg [7:0] group1_polarity_ff;
    reg [7:0] group0_dien_ff;
    reg [7:0] group1_dien_ff;
    reg ack_ff;
    reg [31:0] nxt_readdata;
    wire [15:0] pin_sync;
    wire [15:0] dir_all;
    wire [15:0] data_all;
    wire [15:0] dien_all;
    wire [15:0] out_en_all;
    wire [15:0] in_buf;
    wire access;
    wire wr_en;

    // returns the pin data word: register bit when output, buffered pin otherwise
    function [7:0] data_view;
        input [7:0] dir;
        input [7:0] reg_val;
        input [7:0] pin_val;
        begin
            data_view = (dir & reg_val) | (~dir & pin_val);
        end
    endfunction

    // merges a write byte into a register under byte-lane 0
    function [7:0] merge_byte;
        input [7:0] old_val;
        input [31:0] wdata;
        input [3:0] be;
        begin
            merge_byte = be[0] ? wdata[7:0] : old_val;
        end
    endfunction

////////////////////////////////////////////////////////////////////////////////
// input path

    // registered pin_oe plus the synchronisers make the data read lag a direction change by up to three cycles
    apc_pin_sync u_sync (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .pin_in(pin_in),
        .pin_sync(pin_sync)
    );

    assign dir_all = {upper_pin_direction_ff, lower_pin_direction_ff};
    assign data_all = {upper_pin_data_ff, lower_pin_data_ff};
    assign dien_all = {group1_dien_ff, group0_dien_ff};
    assign in_buf = pin_sync & dien_all;

////////////////////////////////////////////////////////////////////////////////
// bus slave: one wait cycle, then acknowledge

    assign access = (avs_read | avs_write) & ~ack_ff;
    assign wr_en = avs_write & ~ack_ff;

    always @* begin
        nxt_readdata = `APC_UNMAPPED_DATA;
        case (avs_address)
            `APC_OFS_LOW_DATA: nxt_readdata[7:0] = data_view(lower_pin_direction_ff, lower_pin_data_ff, in_buf[7:0]);
            `APC_OFS_UP_DATA: nxt_readdata[7:0] = data_view(upper_pin_direction_ff, upper_pin_data_ff, in_buf[15:8]);
            `APC_OFS_LOW_DIR: nxt_readdata[7:0] = lower_pin_direction_ff;
            `APC_OFS_UP_DIR: nxt_readdata[7:0] = upper_pin_direction_ff;
            `APC_OFS_DRV0: nxt_readdata[7:0] = group0_drive_strength_ff;
            `APC_OFS_DRV1: nxt_readdata[7:0] = group1_drive_strength_ff;
            `APC_OFS_PULL0: nxt_readdata[7:0] = group0_pull_enable_ff;
            `APC_OFS_PULL1: nxt_readdata[7:0] = group1_pull_enable_ff;
            `APC_OFS_POL0: nxt_readdata[7:0] = group0_polarity_ff;
            `APC_OFS_POL1: nxt_readdata[7:0] = group1_polarity_ff;
            `APC_OFS_DIEN0: nxt_readdata[7:0] = group0_dien_ff;
            `APC_OFS_DIEN1: nxt_readdata[7:0] = group1_dien_ff;
            default: nxt_readdata = `APC_UNMAPPED_DATA;
        endcase
    end

    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ack_ff <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata <= `APC_UNMAPPED_DATA;
        end else begin
            ack_ff <= access;
            avs_waitrequest <= ~access;
            if (avs_read & ~ack_ff) begin
                avs_readdata <= nxt_readdata;
            end
        end
    end

////////////////////////////////////////////////////////////////////////////////
// configuration registers

    // all reset to zero, pins start as inputs
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            lower_pin_data_ff <= `APC_RST_BYTE;
            upper_pin_data_ff <= `APC_RST_BYTE;
            lower_pin_direction_ff <= `APC_RST_BYTE;
            upper_pin_direction_ff <= `APC_RST_BYTE;
            group0_drive_strength_ff <= `APC_RST_BYTE;
            group1_drive_strength_ff <= `APC_RST_BYTE;
            group0_pull_enable_ff <= `APC_RST_BYTE;
            group1_pull_enable_ff <= `APC_RST_BYTE;
            group0_polarity_ff <= `APC_RST_BYTE;
            group1_polarity_ff <= `APC_RST_BYTE;
            group0_dien_ff <= `APC_RST_BYTE;
            group1_dien_ff <= `APC_RST_BYTE;
        end else if (wr_en) begin
            case (avs_address)
                `APC_OFS_LOW_DATA: lower_pin_data_ff <= merge_byte(lower_pin_data_ff, avs_writedata, avs_byteenable);
                `APC_OFS_UP_DATA: upper_pin_data_ff <= merge_byte(upper_pin_data_ff, avs_writedata, avs_byteenable);
                `APC_OFS_LOW_DIR: begin
                    lower_pin_direction_ff <= merge_byte(lower_pin_direction_ff, avs_writedata, avs_byteenable);
                end
                `APC_OFS_UP_DIR: begin
                    upper_pin_direction_ff <= merge_byte(upper_pin_direction_ff, avs_writedata, avs_byteenable);
                end
                `APC_OFS_DRV0: begin
                    group0_drive_strength_ff <= merge_byte(group0_drive_strength_ff, avs_writedata, avs_byteenable);
                end
                `APC_OFS_DRV1: begin
                    group1_drive_strength_ff <= merge_byte(group1_drive_strength_ff, avs_writedata, avs_byteenable);
                end
                `APC_OFS_PULL0: group0_pull_enable_ff <= merge_byte(group0_pull_enable_ff, avs_writedata, avs_byteenable);
                `APC_OFS_PULL1: group1_pull_enable_ff <= merge_byte(group1_pull_enable_ff, avs_writedata, avs_byteenable);
                `APC_OFS_POL0: group0_polarity_ff <= merge_byte(group0_polarity_ff, avs_writedata, avs_byteenable);
                `APC_OFS_POL1: group1_polarity_ff <= merge_byte(group1_polarity_ff, avs_writedata, avs_byteenable);
                `APC_OFS_DIEN0: group0_dien_ff <= merge_byte(group0_dien_ff, avs_writedata, avs_byteenable);
                `APC_OFS_DIEN1: group1_dien_ff <= merge_byte(group1_dien_ff, avs_writedata, avs_byteenable);
                default: begin
                end
            endcase
        end
    end

////////////////////////////////////////////////////////////////////////////////
// pad controls, registered

    // alternate function overrides direction and data when it claims the pin
    assign out_en_all = alt_out_en | dir_all;

    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_out <= 16'h0000;
            pin_oe <= 16'h0000;
            pin_reduced_drive <= 16'h0000;
            pin_pull_en <= 16'h0000;
            pin_pull_up <= 16'h0000;
            pin_digital_in_en <= 16'h0000;
        end else begin
            pin_oe <= out_en_all;
            pin_out <= (alt_out_en & alt_out_val) | (~alt_out_en & data_all);
            // reduced drive only on outputs, any source
            pin_reduced_drive <= out_en_all & {group1_drive_strength_ff, group0_drive_strength_ff};
            pin_pull_en <= ~out_en_all & {group1_pull_enable_ff, group0_pull_enable_ff};
            pin_pull_up <= ~out_en_all & {group1_pull_enable_ff, group0_pull_enable_ff}
                & {group1_polarity_ff, group0_polarity_ff};
            pin_digital_in_en <= dien_all;
        end
    end

    // stale window comes from the registered pin_oe plus the two-stage sync above
endmodule // apc_port

// ===== testbench/apc_pad_model.sv
/* apc_pad_model: pads and outside world of the sixteen analog-shared pins.
   assumes the bench drives ext_en only on pins the block does not drive. */
module apc_pad_model (
    input wire sys_clk,
    input wire [15:0] pin_out, pin_oe, pin_pull_en, pin_pull_up,
    input wire [15:0] ext_en, ext_val,
    output wire [15:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ns;
    // a floating pad toggles so a stale level can never pass for a match
    logic [15:0] float_ff = 16'h0000;
    always @(posedge sys_clk) float_ff <= ~float_ff;
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
        | (~pin_oe & ~ext_en & pin_pull_en & pin_pull_up) | (~pin_oe & ~ext_en & ~pin_pull_en & float_ff);
endmodule // apc_pad_model

// ===== testbench/apc_port_chk.sv
/* apc_port_chk: bus and pad-control assertions for apc_port.
   assumes alt_out_en stays low across every reset. */
module apc_port_chk (
    input wire sys_clk, arst_n, avs_read, avs_write, avs_waitrequest,
    input wire [9:0] avs_address,
    input wire [31:0] avs_readdata,
    input wire [15:0] alt_out_en, alt_out_val, pin_out, pin_oe,
    input wire [15:0] pin_reduced_drive, pin_pull_en, pin_pull_up
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    ////////////////////////////////////////////////////////////
    chk_ack_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("waitrequest not low one cycle after request");
    chk_idle_no_ack: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
        else $error("waitrequest low without request");
    chk_unmapped_zero: assert property (avs_read && !avs_waitrequest && (avs_address < 10'h270 || avs_address > 10'h27B)
        |-> avs_readdata == 32'h00000000)
        else $error("unmapped read not zero");
    chk_read_upper_zero: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h000000)
        else $error("readdata upper bits set");
    chk_alt_sets_oe: assert property (alt_out_en != 16'h0000 |=> (~pin_oe & $past(alt_out_en)) == 16'h0000)
        else $error("alternate pin not output");
    chk_alt_value: assert property (alt_out_en != 16'h0000 |=> ((pin_out ^ $past(alt_out_val)) & $past(alt_out_en)) == 16'h0000)
        else $error("alternate value not driven");
    chk_drive_input: assert property ((pin_reduced_drive & ~pin_oe) == 16'h0000)
        else $error("reduced drive on input pin");
    chk_pull_output: assert property ((pin_pull_en & pin_oe) == 16'h0000)
        else $error("pull device on output pin");
    chk_pull_up_gated: assert property ((pin_pull_up & ~pin_pull_en) == 16'h0000)
        else $error("pull up without pull enable");
endmodule // apc_port_chk

bind apc_port apc_port_chk u_apc_port_chk (.sys_clk(sys_clk), .arst_n(arst_n), .avs_read(avs_read),
    .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .avs_address(avs_address),
    .avs_readdata(avs_readdata), .alt_out_en(alt_out_en), .alt_out_val(alt_out_val), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_reduced_drive(pin_reduced_drive), .pin_pull_en(pin_pull_en), .pin_pull_up(pin_pull_up));

// ===== testbench/tb_top.sv
/* tb_top: directed regression of apc_port over Avalon-MM and its pads.
   assumes the pad model loops outputs back and applies pulls. */
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0, arst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
    logic [9:0] avs_address = 10'h000;
    logic [31:0] avs_writedata = 32'h00000000, avs_readdata;
    logic [3:0] avs_byteenable = 4'hF;
    logic [15:0] alt_out_en = 16'h0000, alt_out_val = 16'h0000, ext_en = 16'h0000, ext_val = 16'h0000;
    logic [15:0] pin_in, pin_out, pin_oe, pin_reduced_drive, pin_pull_en, pin_pull_up, pin_digital_in_en;
    logic [7:0] rd;
    int err_count = 0, compares = 0;
    always #50 sys_clk = ~sys_clk;
    apc_port u_apc_port (.sys_clk(sys_clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pin_in(pin_in), .alt_out_en(alt_out_en),
        .alt_out_val(alt_out_val), .pin_out(pin_out), .pin_oe(pin_oe), .pin_reduced_drive(pin_reduced_drive),
        .pin_pull_en(pin_pull_en), .pin_pull_up(pin_pull_up), .pin_digital_in_en(pin_digital_in_en));
    apc_pad_model u_apc_pad_model (.sys_clk(sys_clk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pull_en(pin_pull_en), .pin_pull_up(pin_pull_up), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));
    ////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        if (err_count == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // request held until waitrequest is sampled low, then released
    task automatic bus(input logic wr, input logic [9:0] a, input logic [7:0] d, input logic [3:0] be);
        int n;
        @(posedge sys_clk);
        avs_read <= !wr;
        avs_write <= wr;
        avs_address <= a;
        avs_writedata <= {24'h000000, d};
        avs_byteenable <= be;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        rd = avs_readdata[7:0];
        if (avs_waitrequest !== 1'b0) begin
            err_count++;
            tally_and_finish;
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        bus(1'b1, a, d, 4'h1);
    endtask
    task automatic rdchk(input logic [9:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00, 4'hF);
        chk("readdata", {8'h00, e}, {8'h00, rd});
    endtask
    task automatic settle;
        repeat (3) @(posedge sys_clk);
    endtask
    ////////////////////////////////////////////////////////////
    task automatic t_reset;
        for (int a = 'h270; a <= 'h27B; a++) rdchk(a[9:0], 8'h00);
        rdchk(10'h280, 8'h00);
    endtask
    task automatic t_regs;
        for (int a = 'h272; a <= 'h27B; a++) begin
            wr(a[9:0], 8'hA5 ^ a[7:0]);
            rdchk(a[9:0], 8'hA5 ^ a[7:0]);
        end
        bus(1'b1, 10'h272, 8'hFF, 4'h0);
        rdchk(10'h272, 8'hD7);
        wr(10'h280, 8'hFF);
        rdchk(10'h280, 8'h00);
    endtask
    task automatic t_pins;
        logic [7:0] cfg [8] = '{8'h3C, 8'h81, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h0F, 8'hF0};
        for (int i = 0; i < 8; i++) wr(10'h272 + i[9:0], cfg[i]);
        settle;
        chk("pin_oe", 16'h813C, pin_oe);
        chk("pin_reduced_drive", 16'h813C, pin_reduced_drive);
        chk("pin_pull_en", 16'h7EC3, pin_pull_en);
        chk("pin_pull_up", 16'h7003, pin_pull_up);
        wr(10'h274, 8'h00);
        settle;
        chk("pin_reduced_drive", 16'h8100, pin_reduced_drive);
    endtask
    task automatic t_alt;
        @(posedge sys_clk);
        alt_out_en <= 16'h0201;
        alt_out_val <= 16'h0200;
        settle;
        chk("pin_oe", 16'h833D, pin_oe);
        chk("pin_reduced_drive", 16'h8300, pin_reduced_drive);
        chk("pin_out", 16'h0200, pin_out & 16'h0201);
        chk("pin_pull_en", 16'h7CC2, pin_pull_en);
        alt_out_en <= 16'h0000;
    endtask
    task automatic t_data;
        wr(10'h27A, 8'hFF);
        wr(10'h270, 8'h5A);
        ext_en <= 16'h00C3;
        ext_val <= 16'h0081;
        settle;
        rdchk(10'h270, 8'h99);
        wr(10'h27A, 8'h00);
        rdchk(10'h270, 8'h18);
        wr(10'h27A, 8'hFF);
        wr(10'h272, 8'h00);
        settle;
        rdchk(10'h270, 8'h8D);
        chk("pin_digital_in_en", 16'hDEFF, pin_digital_in_en);
    endtask
    initial begin
        repeat (5) @(posedge sys_clk);
        arst_n <= 1'b1;
        t_reset;
        t_regs;
        t_pins;
        t_alt;
        t_data;
        tally_and_finish;
    end
endmodule // tb_top
